// ===== hw/dma_shmem_pkg.sv
package dma_shmem_pkg;
	// Bus geometry
	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 16;
	localparam int RT_N    = 32;
	localparam int RT_ID_W = 5;
	localparam int SLOT_W  = 7;
	localparam int CNT_W   = 4;
	// Receive buffering depth in messages per subaddress
	localparam int BUF_MSGS = 128;
	// Strobe width of one RAM access in master clock cycles
	localparam int ACCESS_CYCLES = 2;
	// Reset and step values
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [15:0] ADDR_ONE   = 16'h0001;
	localparam logic [6:0]  SLOT_RESET = 7'h00;
	localparam logic [6:0]  SLOT_ONE   = 7'h01;
	localparam logic [6:0]  SLOT_LAST  = 7'h7f;
	localparam logic [3:0]  CNT_RESET  = 4'h0;
	localparam logic [3:0]  CNT_ONE    = 4'h1;
	// Transfer sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_REQ  = 5'b00010,
		ST_OWN  = 5'b00100,
		ST_ACC  = 5'b01000,
		ST_REL  = 5'b10000
	} dma_state_t;
endpackage : dma_shmem_pkg

// ===== hw/dma_shared_memory_interface.sv
// Operation
// - Address a host-defined shared region of up to 64K words.
// - Step a receive buffer slot per message, up to 128 per subaddress.
// - Access rate follows master clock; strobe width is a cycle count.
// - Log each interrupt event accepted while none is pending sequentially into a memory history list.
// - Monitor stores command and data where host command blocks point.
// - Monitor stores traffic only for host-selected terminals when enabled.
// - Monitor blocks lack head pointer; data flows opposite to controller mode.
// - Start memory cycles for controller blocks or serviced terminal commands.
// - Transfer begins with request low, ends when acknowledge returns high.
// - Drive address only while the address enable input permits.
// - Pass incoming grant to chain output when not requesting.
// - Pseudo-dual-port: forward host read, write, select strobes to RAM.
// - Own RAM strobes only become active after the grant.
// - Tristate buses unless register read or own access; ignore host then.
// - Ignore host memory strobes while own RAM transfer runs.
// - Assert burst output for consecutive accesses under one ownership.
`timescale 1ns/100ps
`default_nettype none
module dma_shared_memory_interface #(
	parameter int ACCESS_CYCLES = dma_shmem_pkg::ACCESS_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        bus_controller_mode,
	input  wire logic        remote_terminal_mode,
	input  wire logic        monitor_mode,
	input  wire logic        pseudo_dual_port,
	input  wire logic        rt_filter_enable,
	input  wire logic [31:0] rt_select,
	input  wire logic [15:0] history_base,
	input  wire logic        core_valid,
	input  wire logic        core_write,
	input  wire logic        core_more,
	input  wire logic        core_capture,
	input  wire logic [4:0]  core_rt,
	input  wire logic [15:0] core_addr,
	input  wire logic [15:0] core_wdata,
	output logic             core_done,
	output logic             core_dropped,
	output logic [15:0]      core_rdata,
	input  wire logic        event_valid,
	input  wire logic [15:0] event_code,
	output logic             event_ready,
	input  wire logic        rt_msg_done,
	output logic [6:0]       rt_buf_slot,
	input  wire logic [15:0] reg_rd_data,
	output logic             mem_request_n,
	input  wire logic        mem_grant_in_n,
	output logic             mem_acknowledge_n,
	output logic             grant_chain_out_n,
	input  wire logic        address_drive_enable,
	output logic             bus_drive_indicator_n,
	output logic             burst_n,
	output logic [15:0]      addr_out,
	output logic             addr_oe_n,
	output logic [15:0]      data_out,
	input  wire logic [15:0] data_in,
	output logic             data_oe_n,
	input  wire logic        host_rd_n,
	input  wire logic        host_wr_n,
	input  wire logic        host_mem_select_n,
	input  wire logic        host_reg_select_n,
	output logic             ram_read_n,
	output logic             ram_write_n,
	output logic             ram_select_n
);
	localparam logic [3:0] ACC_LAST = 4'(ACCESS_CYCLES - 1);

	typedef struct packed {
		dma_shmem_pkg::dma_state_t st;
		logic g1, g2, aen1, aen2;
		logic hrd1, hrd2, hwr1, hwr2, hcs1, hcs2, rcs1, rcs2;
		logic req_n, ack_n, chain_n, drive_n, burst_n;
		logic addr_oe_n, data_oe_n, rrd_n, rwr_n, rsel_n;
		logic [15:0] addr;
		logic [15:0] dout;
		logic [3:0]  cnt;
		logic wr, more, loaded, is_log;
		logic core_done, dropped;
		logic [15:0] rdata;
		logic ev_pend;
		logic ev_ready;
		logic [15:0] ev_code;
		logic [15:0] hist_ptr;
		logic [6:0]  slot;
	} dma_regs_t;

	localparam dma_regs_t REGS_RESET = '{
		st: dma_shmem_pkg::ST_IDLE,
		g1: 1'b1, g2: 1'b1, aen1: 1'b0, aen2: 1'b0,
		hrd1: 1'b1, hrd2: 1'b1, hwr1: 1'b1, hwr2: 1'b1,
		hcs1: 1'b1, hcs2: 1'b1, rcs1: 1'b1, rcs2: 1'b1,
		req_n: 1'b1, ack_n: 1'b1, chain_n: 1'b1, drive_n: 1'b1,
		burst_n: 1'b1, addr_oe_n: 1'b1, data_oe_n: 1'b1,
		rrd_n: 1'b1, rwr_n: 1'b1, rsel_n: 1'b1,
		addr: dma_shmem_pkg::ADDR_RESET, dout: dma_shmem_pkg::DATA_RESET,
		cnt: dma_shmem_pkg::CNT_RESET,
		wr: 1'b0, more: 1'b0, loaded: 1'b0, is_log: 1'b0,
		core_done: 1'b0, dropped: 1'b0,
		rdata: dma_shmem_pkg::DATA_RESET,
		ev_pend: 1'b0, ev_ready: 1'b1, ev_code: dma_shmem_pkg::DATA_RESET,
		hist_ptr: dma_shmem_pkg::ADDR_RESET,
		slot: dma_shmem_pkg::SLOT_RESET
	};

	dma_regs_t s;
	dma_regs_t next_s;

	// Wrapping word increment inside the 64K space
	function automatic logic [15:0] inc_addr(input logic [15:0] a);
		inc_addr = a + dma_shmem_pkg::ADDR_ONE;
	endfunction : inc_addr

	logic any_mode;
	logic filtered_out;
	assign any_mode = bus_controller_mode | remote_terminal_mode | monitor_mode;
	// Capture for an unselected terminal is discarded
	assign filtered_out = monitor_mode & core_capture & rt_filter_enable
		& ~rt_select[core_rt];

	// Sequencer and pin logic
	always_comb
	begin
		next_s = s;
		// Two-stage synchronisers for pin inputs
		next_s.g1 = mem_grant_in_n;
		next_s.g2 = s.g1;
		next_s.aen1 = address_drive_enable;
		next_s.aen2 = s.aen1;
		next_s.hrd1 = host_rd_n;
		next_s.hrd2 = s.hrd1;
		next_s.hwr1 = host_wr_n;
		next_s.hwr2 = s.hwr1;
		next_s.hcs1 = host_mem_select_n;
		next_s.hcs2 = s.hcs1;
		next_s.rcs1 = host_reg_select_n | host_rd_n;
		next_s.rcs2 = s.rcs1;
		next_s.core_done = 1'b0;
		next_s.dropped = 1'b0;
		// Receive buffer slot wraps after the last message slot
		if (rt_msg_done && remote_terminal_mode)
			next_s.slot = (s.slot == dma_shmem_pkg::SLOT_LAST)
				? dma_shmem_pkg::SLOT_RESET
				: s.slot + dma_shmem_pkg::SLOT_ONE;
		// Grant ripples on only while no request of our own
		next_s.chain_n = (s.st == dma_shmem_pkg::ST_IDLE) ? s.g2 : 1'b1;
		case (s.st)
			dma_shmem_pkg::ST_IDLE:
			begin
				// Host strobes pass through only while idle
				next_s.rrd_n = pseudo_dual_port ? s.hrd2 : 1'b1;
				next_s.rwr_n = pseudo_dual_port ? s.hwr2 : 1'b1;
				next_s.rsel_n = pseudo_dual_port ? s.hcs2 : 1'b1;
				// Register read drives data bus only when idle
				next_s.data_oe_n = s.rcs2;
				next_s.dout = s.rcs2 ? s.dout : reg_rd_data;
				if (core_valid && any_mode && !s.core_done && filtered_out)
				begin
					next_s.core_done = 1'b1;
					next_s.dropped = 1'b1;
				end
				else if (core_valid && any_mode && !s.core_done)
				begin
					// Controller block or terminal service starts a cycle
					next_s.addr = core_addr;
					next_s.dout = core_wdata;
					next_s.wr = core_write;
					next_s.more = core_more;
					next_s.is_log = 1'b0;
					next_s.loaded = 1'b1;
					next_s.req_n = 1'b0;
					next_s.data_oe_n = 1'b1;
					next_s.rrd_n = 1'b1;
					next_s.rwr_n = 1'b1;
					next_s.rsel_n = 1'b1;
					next_s.st = dma_shmem_pkg::ST_REQ;
				end
				else if (s.ev_pend)
				begin
					// Next history list entry
					next_s.addr = history_base + s.hist_ptr;
					next_s.hist_ptr = inc_addr(s.hist_ptr);
					next_s.dout = s.ev_code;
					next_s.wr = 1'b1;
					next_s.more = 1'b0;
					next_s.is_log = 1'b1;
					next_s.loaded = 1'b1;
					next_s.ev_pend = 1'b0;
					next_s.req_n = 1'b0;
					next_s.data_oe_n = 1'b1;
					next_s.rrd_n = 1'b1;
					next_s.rwr_n = 1'b1;
					next_s.rsel_n = 1'b1;
					next_s.st = dma_shmem_pkg::ST_REQ;
				end
			end
			dma_shmem_pkg::ST_REQ:
			begin
				// Request stands until grant, then acknowledge
				if (!s.g2)
				begin
					next_s.req_n = 1'b1;
					next_s.ack_n = 1'b0;
					next_s.st = dma_shmem_pkg::ST_OWN;
				end
			end
			dma_shmem_pkg::ST_OWN:
			begin
				if (s.loaded && s.aen2)
				begin
					// Drive buses and open strobes after grant
					next_s.drive_n = 1'b0;
					next_s.addr_oe_n = 1'b0;
					next_s.data_oe_n = ~s.wr;
					next_s.rsel_n = 1'b0;
					next_s.rrd_n = s.wr;
					next_s.rwr_n = ~s.wr;
					next_s.cnt = ACC_LAST;
					next_s.st = dma_shmem_pkg::ST_ACC;
				end
				else if (!s.loaded && !s.core_done && s.more && core_valid)
				begin
					next_s.addr = core_addr;
					next_s.dout = core_wdata;
					next_s.wr = core_write;
					next_s.more = core_more;
					next_s.loaded = 1'b1;
				end
				else if (!s.loaded && !s.more)
					next_s.st = dma_shmem_pkg::ST_REL;
			end
			dma_shmem_pkg::ST_ACC:
			begin
				// Address withdrawn once the synchronised enable (aen2) drops
				if (!s.aen2)
					next_s.addr_oe_n = 1'b1;
				if (s.cnt != dma_shmem_pkg::CNT_RESET)
					next_s.cnt = s.cnt - dma_shmem_pkg::CNT_ONE;
				else
				begin
					next_s.rdata = s.wr ? s.rdata : data_in;
					next_s.core_done = ~s.is_log;
					next_s.loaded = 1'b0;
					next_s.rrd_n = 1'b1;
					next_s.rwr_n = 1'b1;
					next_s.rsel_n = 1'b1;
					next_s.drive_n = 1'b1;
					next_s.addr_oe_n = 1'b1;
					next_s.data_oe_n = 1'b1;
					next_s.burst_n = ~s.more;
					next_s.st = s.more ? dma_shmem_pkg::ST_OWN
						: dma_shmem_pkg::ST_REL;
				end
			end
			dma_shmem_pkg::ST_REL:
			begin
				// Acknowledge high closes the transfer
				next_s.ack_n = 1'b1;
				next_s.burst_n = 1'b1;
				next_s.st = dma_shmem_pkg::ST_IDLE;
			end
			default:
				next_s = REGS_RESET;
		endcase
		// New event accepted only while none is pending; one offered in the take cycle is ignored
		if (event_valid && !s.ev_pend)
		begin
			next_s.ev_pend = 1'b1;
			next_s.ev_code = event_code;
		end
		// Free log slot flag kept as its own flop
		next_s.ev_ready = ~next_s.ev_pend;
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s <= REGS_RESET;
		else if (ce)
			s <= next_s;
	end

	// Outputs straight from flops
	assign mem_request_n = s.req_n;
	assign mem_acknowledge_n = s.ack_n;
	assign grant_chain_out_n = s.chain_n;
	assign bus_drive_indicator_n = s.drive_n;
	assign burst_n = s.burst_n;
	assign addr_out = s.addr;
	assign addr_oe_n = s.addr_oe_n;
	assign data_out = s.dout;
	assign data_oe_n = s.data_oe_n;
	assign ram_read_n = s.rrd_n;
	assign ram_write_n = s.rwr_n;
	assign ram_select_n = s.rsel_n;
	assign core_done = s.core_done;
	assign core_dropped = s.dropped;
	assign core_rdata = s.rdata;
	assign event_ready = s.ev_ready;
	assign rt_buf_slot = s.slot;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_req_until_grant: assert property ((!s.req_n && s.g2 && ce) |=> !s.req_n)
		else $error("request dropped before grant");
	a_ack_after_grant: assert property (($fell(s.ack_n)) |-> $past(!s.g2))
		else $error("acknowledge without grant");
	a_chain_blocked: assert property ((s.st != dma_shmem_pkg::ST_IDLE) |=> s.chain_n)
		else $error("grant passed on while requesting");
	a_addr_needs_aen: assert property ($fell(s.addr_oe_n) |-> $past(s.aen2))
		else $error("address driven without enable");
	a_own_strobe_grant: assert property ((s.st == dma_shmem_pkg::ST_ACC) |-> (!s.ack_n && !s.rsel_n))
		else $error("own strobe outside ownership");
	a_host_ignored: assert property ((s.st != dma_shmem_pkg::ST_IDLE && !s.rsel_n) |-> !s.drive_n)
		else $error("host strobe during own access");
	a_bus_tristate: assert property ((!s.data_oe_n) |-> (!s.drive_n || s.st == dma_shmem_pkg::ST_IDLE))
		else $error("data bus driven without cause");
	a_strobe_width: assert property ((s.st == dma_shmem_pkg::ST_OWN && s.loaded && s.aen2 && ce) |=> (s.st == dma_shmem_pkg::ST_ACC) && s.cnt == ACC_LAST)
		else $error("access count wrong");
	a_release_ack: assert property ((s.st == dma_shmem_pkg::ST_REL && ce) |=> s.ack_n && s.st == dma_shmem_pkg::ST_IDLE)
		else $error("acknowledge not released");
	a_drop_filter: assert property ((s.dropped) |-> $past(filtered_out))
		else $error("capture dropped wrongly");
	a_hist_step: assert property ((s.st == dma_shmem_pkg::ST_IDLE && s.ev_pend && !(core_valid && any_mode && !s.core_done) && ce) |=> s.hist_ptr == inc_addr($past(s.hist_ptr)))
		else $error("history pointer not stepped");

	c_single_write: cover property (s.st == dma_shmem_pkg::ST_ACC && s.wr);
	c_burst: cover property (!s.burst_n && s.st == dma_shmem_pkg::ST_OWN);
	c_event_log: cover property (s.st == dma_shmem_pkg::ST_ACC && s.is_log);
	c_dropped: cover property (s.dropped);
endmodule : dma_shared_memory_interface
`default_nettype wire

// ===== tb/dma_far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module dma_far_side_model (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        mem_request_n,
	input  wire logic        mem_acknowledge_n,
	input  wire logic        chain_grant,
	input  wire logic        slow,
	input  wire logic        ram_read_n,
	input  wire logic        ram_write_n,
	input  wire logic        ram_select_n,
	input  wire logic [15:0] addr_out,
	input  wire logic [15:0] data_out,
	output logic             mem_grant_in_n,
	output logic [15:0]      data_in
);
	// Shared RAM of 64K words
	logic [15:0] mem [0:65535];
	logic [1:0]  lag;
	// Arbiter: grant after optional wait, held until acknowledge returns
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mem_grant_in_n <= 1'b1;
			lag            <= 2'h0;
		end
		else
		begin
			lag <= mem_request_n ? 2'h0 : lag + 2'h1;
			mem_grant_in_n <= !(chain_grant || !mem_acknowledge_n ||
				(!mem_request_n && (!slow || !mem_grant_in_n || lag == 2'h3)));
		end
	end
	// One-cycle RAM access; a released bus toggles every cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			data_in <= 16'h0000;
		else
		begin
			if (!ram_select_n && !ram_write_n)
				mem[addr_out] <= data_out;
			data_in <= (!ram_select_n && !ram_read_n) ? mem[addr_out] : ~data_in;
		end
	end
endmodule : dma_far_side_model
`default_nettype wire

// ===== tb/dma_shared_memory_interface_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module dma_shared_memory_interface_bench;
	// Pins of the block and its far side
	logic clk_sys = 1'b0, rst = 1'b1, ce, bus_controller_mode, monitor_mode;
	logic remote_terminal_mode, pseudo_dual_port, rt_filter_enable, core_valid;
	logic core_write, core_more, core_capture, event_valid, rt_msg_done, slow;
	logic address_drive_enable, host_rd_n, host_wr_n, host_mem_select_n;
	logic host_reg_select_n, chain_grant, core_done, core_dropped, event_ready;
	logic mem_request_n, mem_grant_in_n, mem_acknowledge_n, grant_chain_out_n;
	logic bus_drive_indicator_n, burst_n, addr_oe_n, data_oe_n, ram_read_n;
	logic ram_write_n, ram_select_n, drp, saw_burst;
	logic [31:0] rt_select;
	logic [15:0] history_base, core_addr, core_wdata, core_rdata, event_code;
	logic [15:0] reg_rd_data, addr_out, data_out, data_in, a, d;
	logic [6:0]  rt_buf_slot;
	logic [4:0]  core_rt;
	int n_mismatch = 0, total_checks = 0, i, k;

	always #4 clk_sys = ~clk_sys;

	dma_shared_memory_interface DUT (.*);
	dma_far_side_model far (.*);

	// Ownership watch, just after each rising edge
	always @(posedge clk_sys)
	begin
		#1;
		if (burst_n === 1'b0)
			saw_burst = 1'b1;
		if (bus_drive_indicator_n === 1'b0)
			`CHK(mem_acknowledge_n, 1'b0)
		if (bus_drive_indicator_n === 1'b0 && core_write === 1'b1)
			`CHK(ram_read_n, 1'b1)
		if (!pseudo_dual_port && mem_grant_in_n === 1'b1)
			`CHK(ram_select_n, 1'b1)
	end

	function automatic logic [6:0] exp_slot(input int n);
		return 7'(n % 128);
	endfunction : exp_slot

	task automatic mode(input logic [2:0] m);
		{bus_controller_mode, remote_terminal_mode, monitor_mode} = m;
	endtask : mode

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic wait_done;
		for (k = 0; k < 300 && core_done !== 1'b1; k++)
		begin
			@(posedge clk_sys);
			#1;
		end
		if (k == 300)
		begin
			n_mismatch++;
			test_done;
		end
		drp = core_dropped;
		@(negedge clk_sys);
	endtask : wait_done

	// One access, started at a falling edge
	task automatic acc(input logic w, m, input logic [15:0] ad, wd);
		{core_valid, core_write, core_more, core_addr, core_wdata} =
			{1'b1, w, m, ad, wd};
		wait_done;
		if (!m)
		begin
			core_valid = 1'b0;
			repeat (4) @(negedge clk_sys);
		end
	endtask : acc

	initial
	begin
		{bus_controller_mode, remote_terminal_mode, monitor_mode, core_valid,
			pseudo_dual_port, rt_filter_enable, core_write, core_more, slow,
			core_capture, event_valid, rt_msg_done, chain_grant, saw_burst} = '0;
		{ce, host_rd_n, host_wr_n, host_mem_select_n, host_reg_select_n,
			address_drive_enable} = '1;
		{rt_select, history_base, core_addr, core_wdata, event_code,
			reg_rd_data, core_rt} = '0;
		void'($urandom(26));
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		`CHK({mem_request_n, mem_acknowledge_n, addr_oe_n, data_oe_n}, 4'hf)
		// Writes and read-backs in every mode, edge addresses first
		for (i = 0; i < 9; i++)
		begin
			mode(3'b100 >> (i % 3));
			a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
			d = 16'($urandom);
			slow = i[0];
			acc(1'b1, 1'b0, a, d);
			`CHK(far.mem[a], d)
			acc(1'b0, 1'b0, a, 16'h0000);
			`CHK(core_rdata, d)
		end
		// Three writes under one ownership
		mode(3'b100);
		for (i = 0; i < 3; i++)
			acc(1'b1, i < 2, 16'h0100 + 16'(i), 16'ha5a0 + 16'(i));
		`CHK(saw_burst, 1'b1)
		`CHK(far.mem[16'h0102], 16'ha5a2)
		// Address held back while the enable is low
		address_drive_enable = 1'b0;
		{core_valid, core_write, core_addr, core_wdata} = {2'b11, 32'h0200_1234};
		repeat (20) @(negedge clk_sys);
		`CHK(addr_oe_n, 1'b1)
		address_drive_enable = 1'b1;
		wait_done;
		core_valid = 1'b0;
		`CHK(far.mem[16'h0200], 16'h1234)
		$display("access tests ended");
		// No mode: request refused; grant passes down the chain
		mode(3'b000);
		core_valid = 1'b1;
		chain_grant = 1'b1;
		repeat (20) @(negedge clk_sys);
		`CHK({mem_request_n, grant_chain_out_n}, 2'b10)
		{core_valid, chain_grant} = 2'b00;
		// Capture dropped for an unselected terminal
		{monitor_mode, rt_filter_enable, core_capture} = 3'b111;
		core_rt = 5'($urandom);
		for (i = 0; i < 2; i++)
		begin
			rt_select = (32'h1 << core_rt) ^ {32{i == 0}};
			acc(1'b1, 1'b0, 16'h0300, 16'(i));
			`CHK(drp, i == 0)
		end
		`CHK(far.mem[16'h0300], 16'h0001)
		{monitor_mode, rt_filter_enable, core_capture} = 3'b000;
		// Interrupt events logged in sequence
		mode(3'b100);
		history_base = 16'h4000;
		for (i = 0; i < 2; i++)
		begin
			d = 16'($urandom);
			{event_valid, event_code} = {1'b1, d};
			@(negedge clk_sys);
			event_valid = 1'b0;
			for (k = 0; k < 100 && far.mem[16'h4000 + 16'(i)] !== d; k++)
				@(negedge clk_sys);
			if (k == 100)
			begin
				n_mismatch++;
				test_done;
			end
			`CHK(far.mem[16'h4000 + 16'(i)], d)
		end
		// Receive slots wrap after the last one
		mode(3'b010);
		for (i = 0; i < 260; i++)
		begin
			rt_msg_done = !i[0];
			@(negedge clk_sys);
		end
		`CHK(rt_buf_slot, exp_slot(130))
		$display("event tests ended");
		// Host strobes forwarded, then a register read
		pseudo_dual_port = 1'b1;
		{host_mem_select_n, host_rd_n} = 2'b00;
		repeat (6) @(negedge clk_sys);
		`CHK({ram_select_n, ram_read_n, ram_write_n}, 3'b001)
		acc(1'b1, 1'b0, 16'h0400, 16'hbeef);
		`CHK(far.mem[16'h0400], 16'hbeef)
		{host_rd_n, host_wr_n} = 2'b10;
		repeat (6) @(negedge clk_sys);
		`CHK({ram_select_n, ram_read_n, ram_write_n}, 3'b010)
		{host_mem_select_n, host_wr_n, host_reg_select_n, host_rd_n} = 4'hc;
		reg_rd_data = 16'($urandom);
		repeat (6) @(negedge clk_sys);
		`CHK({data_oe_n, data_out}, {1'b0, reg_rd_data})
		$display("host tests ended");
		test_done;
	end
endmodule : dma_shared_memory_interface_bench
`default_nettype wire
